// ---- dv/rcg_far_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module rcg_far_model (
    input wire logic pclk,
    input wire logic soft_cmd,
    output logic backplane_sys_clk,
    output logic osc_20m,
    output logic soft_reset_req_n
);
    int acc16 = 0;
    int acc20 = 0;

    // quiet levels at time zero
    initial begin
        backplane_sys_clk = 1'b0;
        osc_20m = 1'b0;
        soft_reset_req_n = 1'b1;
    end

    ////////////////////////////////////////////////////////////////
    // backplane and local oscillator by phase accumulation; both run free
    // fixed average ratio to pclk, 32 and 40 toggles per 50 cycles, so edge spacing varies by a cycle
    always @(posedge pclk) begin
        if (acc16 >= 18) begin
            acc16 <= acc16 - 18;
            backplane_sys_clk <= ~backplane_sys_clk;
        end else begin
            acc16 <= acc16 + 32;
        end
        if (acc20 >= 10) begin
            acc20 <= acc20 - 10;
            osc_20m <= ~osc_20m;
        end else begin
            acc20 <= acc20 + 40;
        end
    end

    ////////////////////////////////////////////////////////////////
    // interface chip drops its request after a soft reset command
    always @(posedge pclk) begin
        soft_reset_req_n <= ~soft_cmd;
    end
endmodule
`default_nettype wire

// ---- dv/rcg_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module testbench;
    localparam int POR_N = 16;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic supply_5v_valid = 1'b1;
    logic relay_supply_ok = 1'b1;
    logic factory_test_n = 1'b1;
    logic osc_20m_fitted = 1'b0;
    logic [2:0] clk_sel_strap = 3'h1;
    logic soft_cmd = 1'b0;
    wire logic [31:0] prdata;
    wire logic pready, pslverr, irq, soft_reset_req_n, backplane_sys_clk, osc_20m;
    wire logic halt_n, hard_reset_n, hard_reset_true, board_reset_n;
    wire logic buffered_sys_clk, clk_8m, timer_clk, cpu_clk;
    int err_total = 0;
    int cmp_count = 0;
    int seed = 32'hafc4;
    int hi_cnt = 0;
    int fell_age = 100;
    int since = 0;
    int age = 0;
    int n_buf, n_8m, n_4m, n_cpu;
    logic soft_en_exp = 1'b1;
    logic req_prev = 1'b1;
    logic sup_prev = 1'b1;
    logic [3:0] ck_prev = 4'h0;

    rcg_top #(.POR_DELAY_CYC(POR_N)) dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq(irq), .supply_5v_valid(supply_5v_valid),
        .relay_supply_ok(relay_supply_ok), .soft_reset_req_n(soft_reset_req_n),
        .factory_test_n(factory_test_n), .backplane_sys_clk(backplane_sys_clk),
        .osc_20m(osc_20m), .osc_20m_fitted(osc_20m_fitted), .clk_sel_strap(clk_sel_strap),
        .halt_n(halt_n), .hard_reset_n(hard_reset_n), .hard_reset_true(hard_reset_true),
        .board_reset_n(board_reset_n), .buffered_sys_clk(buffered_sys_clk),
        .clk_8m(clk_8m), .timer_clk(timer_clk), .cpu_clk(cpu_clk));
    rcg_far_model far_u (.pclk(pclk), .soft_cmd(soft_cmd),
        .backplane_sys_clk(backplane_sys_clk), .osc_20m(osc_20m),
        .soft_reset_req_n(soft_reset_req_n));

    // 50 MHz
    initial begin
        forever #10 pclk = ~pclk;
    end

    ////////////////////////////////////////////////////////////////
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // counts may slip one edge at each end of the window
    task automatic near(input int got, input int exp, input string what);
        cmp_count++;
        if (got < exp - 2 || got > exp + 2) begin
            err_total++;
            $display("ERROR t=%0t %s count %0d exp %0d", $time, what, got, exp);
        end
    endtask
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // one apb transfer; request held until pready is seen at an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic er);
        int n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        cmp({31'h0, pready}, 32'h1, "apb answer");
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask
    task automatic chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x,
                       input string what);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        cmp(r & m, x, what);
    endtask
    task automatic do_reset;
        presetn <= 1'b0;
        wt(12);
        presetn <= 1'b1;
        wt(POR_N + 30);
    endtask
    task automatic soft_pulse;
        soft_cmd <= 1'b1;
        wt(3 + ($unsigned($random(seed)) % 8));
        soft_cmd <= 1'b0;
        wt(30);
    endtask

    ////////////////////////////////////////////////////////////////
    // cycle reference of the reset chain, plus clock edge counts
    always @(negedge pclk) begin
        if (!presetn) begin
            hi_cnt = 0;
            age = 0;
            req_prev = 1'b1;
            since = 0;
        end else begin
            age++;
            if (age > 2) begin
                cmp({31'h0, hard_reset_n}, {31'h0, halt_n}, "hard reset low copy");
                cmp({31'h0, hard_reset_true}, {31'h0, ~halt_n}, "hard reset true copy");
                if (hi_cnt <= POR_N - 3 && fell_age >= 3) cmp({31'h0, halt_n}, 32'h0, "halt early");
                if (hi_cnt >= POR_N + 4) cmp({31'h0, halt_n}, 32'h1, "halt late");
                if (req_prev) cmp({31'h0, board_reset_n}, 32'h0, "board reset held");
                if (since >= 14) cmp({31'h0, board_reset_n}, 32'h1, "board reset stuck");
            end
            req_prev = hard_reset_true | (~soft_reset_req_n & factory_test_n & soft_en_exp);
            since = req_prev ? 0 : since + 1;
            hi_cnt = supply_5v_valid ? hi_cnt + 1 : 0;
        end
        fell_age = (sup_prev && !supply_5v_valid) ? 0 : fell_age + 1;
        sup_prev = supply_5v_valid;
        n_buf += int'(buffered_sys_clk && !ck_prev[0]);
        n_8m += int'(clk_8m && !ck_prev[1]);
        n_4m += int'(timer_clk && !ck_prev[2]);
        n_cpu += int'(cpu_clk && !ck_prev[3]);
        ck_prev = {cpu_clk, timer_clk, clk_8m, buffered_sys_clk};
    end

    // watchdog
    initial begin
        wt(30000);
        err_total++;
        $display("ERROR t=%0t run did not finish", $time);
        end_sim();
    end

    ////////////////////////////////////////////////////////////////
    initial begin
        // straps: third alone 8 MHz (slow emulator case), first 16, second 20 only if fitted
        logic [2:0] st [5] = '{3'h4, 3'h1, 3'h2, 3'h2, 3'h3};
        logic fit [5] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
        logic [1:0] sel [5] = '{2'b01, 2'b00, 2'b10, 2'b00, 2'b00};
        int rate [5] = '{160, 320, 400, 320, 320};
        logic [31:0] r;
        logic e;
        for (int i = 0; i < 5; i++) begin
            clk_sel_strap <= st[i];
            osc_20m_fitted <= fit[i];
            do_reset();
            {n_buf, n_8m, n_4m, n_cpu} = '0;
            wt(1000);
            near(n_buf, 320, "buffered clock");
            near(n_8m, 160, "8 MHz clock");
            near(n_4m, 80, "timer clock");
            near(n_cpu, rate[i], "cpu clock");
            chk(rcg_pkg::ADDR_STATUS, 32'h7f, {25'h0, sel[i], 5'h1d}, "status");
        end
        $display("test straps done");
        chk(rcg_pkg::ADDR_CTRL, 32'h1, 32'h1, "ctrl reset");
        chk(rcg_pkg::ADDR_IRQ_MASK, 32'h7, 32'h0, "mask reset");
        for (int k = 0; k < 4; k++) begin
            r = $random(seed);
            wr(rcg_pkg::ADDR_IRQ_MASK, r);
            chk(rcg_pkg::ADDR_IRQ_MASK, 32'h7, r & 32'h7, "mask readback");
        end
        wr(rcg_pkg::ADDR_IRQ_ST, 32'h7);
        wr(rcg_pkg::ADDR_IRQ_MASK, 32'h2);
        chk(rcg_pkg::ADDR_IRQ_ST, 32'h7, 32'h0, "irq clear");
        soft_pulse();
        chk(rcg_pkg::ADDR_IRQ_ST, 32'h7, 32'h2, "soft event");
        cmp({31'h0, irq}, 32'h1, "irq raised");
        wr(rcg_pkg::ADDR_IRQ_ST, 32'h2);
        wt(3);
        cmp({31'h0, irq}, 32'h0, "irq cleared");
        $display("test soft reset done");
        for (int m = 0; m < 2; m++) begin
            if (m == 0) factory_test_n <= 1'b0;
            else wr(rcg_pkg::ADDR_CTRL, 32'h0);
            soft_en_exp = (m == 0);
            wt(3);
            if (m == 0) chk(rcg_pkg::ADDR_STATUS, 32'h10, 32'h0, "factory test bit");
            soft_pulse();
            chk(rcg_pkg::ADDR_IRQ_ST, 32'h7, 32'h0, "soft inhibited");
            factory_test_n <= 1'b1;
            wr(rcg_pkg::ADDR_CTRL, 32'h1);
            soft_en_exp = 1'b1;
        end
        $display("test inhibit done");
        relay_supply_ok <= 1'b0;
        wt(5);
        chk(rcg_pkg::ADDR_STATUS, 32'h8, 32'h0, "relay low");
        chk(rcg_pkg::ADDR_IRQ_ST, 32'h7, 32'h1, "relay event");
        cmp({31'h0, irq}, 32'h0, "irq masked");
        relay_supply_ok <= 1'b1;
        wr(rcg_pkg::ADDR_IRQ_ST, 32'h7);
        supply_5v_valid <= 1'b0;
        wt(10);
        cmp({30'h0, halt_n, board_reset_n}, 32'h0, "supply loss");
        supply_5v_valid <= 1'b1;
        wt(POR_N + 30);
        chk(rcg_pkg::ADDR_IRQ_ST, 32'h7, 32'h4, "supply event");
        $display("test supplies done");
        apb(1'b0, 8'h10, 32'h0, r, e);
        cmp({e, r[30:0]}, 32'h8000_0000, "unmapped read");
        wr(8'h10, $random(seed));
        wr(rcg_pkg::ADDR_STATUS, 32'hffff_ffff);
        chk(rcg_pkg::ADDR_STATUS, 32'h7f, 32'h1d, "status read only");
        $display("test refusals done");
        end_sim();
    end
endmodule
`default_nettype wire

// ---- verilog/rcg_clk_gen.sv ----
`timescale 1ns/10ps
`default_nettype none
module rcg_clk_gen (
    input wire logic pclk,
    input wire logic presetn,
    rcg_clk_if.gen cif
);

    typedef struct packed {
        logic buf_clk;
        logic c8;
        logic c4;
        logic osc;
        logic cpu;
        logic cpu_rise;
    } rcg_gen_state_t;

    rcg_gen_state_t st_reg;
    rcg_gen_state_t st_next;

    ////////////////////////////////////////////////////////////////////////
    // dividers toggle on the sampled edge, so 8m and 4m stay phase-locked
    always_comb begin
        st_next = st_reg;
        st_next.buf_clk = cif.sys_clk_in;
        st_next.osc = cif.osc_in;
        if (rcg_pkg::rcg_rise(cif.sys_clk_in, st_reg.buf_clk)) begin
            st_next.c8 = ~st_reg.c8;
            if (!st_reg.c8) begin
                st_next.c4 = ~st_reg.c4;
            end
        end
        // one clock for cpu and interface chip
        case (cif.sel)
            rcg_pkg::RCG_SEL_8M: st_next.cpu = st_next.c8;
            rcg_pkg::RCG_SEL_20M: st_next.cpu = st_next.osc;
            rcg_pkg::RCG_SEL_16M: st_next.cpu = st_next.buf_clk;
            default: st_next.cpu = st_next.buf_clk;
        endcase
        st_next.cpu_rise = rcg_pkg::rcg_rise(st_next.cpu, st_reg.cpu);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign cif.buffered = st_reg.buf_clk;
    assign cif.clk_8m = st_reg.c8;
    assign cif.clk_4m = st_reg.c4;
    assign cif.cpu_clk = st_reg.cpu;
    assign cif.cpu_rise = st_reg.cpu_rise;

endmodule
`default_nettype wire

// ---- verilog/rcg_clk_if.sv ----
`timescale 1ns/10ps
`default_nettype none
interface rcg_clk_if;
    logic sys_clk_in;
    logic osc_in;
    rcg_pkg::rcg_clk_sel_t sel;
    logic buffered;
    logic clk_8m;
    logic clk_4m;
    logic cpu_clk;
    logic cpu_rise;

    modport gen(
        input sys_clk_in, osc_in, sel,
        output buffered, clk_8m, clk_4m, cpu_clk, cpu_rise
    );
    modport ctl(
        output sys_clk_in, osc_in, sel,
        input buffered, clk_8m, clk_4m, cpu_clk, cpu_rise
    );
endinterface
`default_nettype wire

// ---- verilog/rcg_pkg.sv ----
package rcg_pkg;

    // pclk rate and power-on hold-off
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int unsigned POR_DELAY_US = 1000;
    localparam int unsigned POR_DELAY_CYC = POR_DELAY_US * (CLK_HZ / 1_000_000);
    localparam int CNT_W = 20;

    // apb register map, byte addresses
    localparam int ADDR_W = 8;
    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_CTRL = 8'h04;
    localparam logic [7:0] ADDR_IRQ_ST = 8'h08;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h0c;
    localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

    // status fields
    localparam int ST_HALT_N = 0;
    localparam int ST_HARD_TRUE = 1;
    localparam int ST_BOARD_N = 2;
    localparam int ST_RELAY_OK = 3;
    localparam int ST_FTEST_N = 4;
    localparam int ST_SEL_LSB = 5;

    // control fields and reset values
    localparam int CTRL_SOFT_EN = 0;
    localparam logic CTRL_SOFT_EN_RST = 1'b1;

    // interrupt sources
    localparam int IRQ_W = 3;
    localparam int IRQ_RELAY_LOW = 0;
    localparam int IRQ_SOFT_RST = 1;
    localparam int IRQ_SUPPLY_LOSS = 2;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;

    // select straps: first, second, third
    localparam int STRAP_16M = 0;
    localparam int STRAP_20M = 1;
    localparam int STRAP_8M = 2;

    typedef enum logic [1:0] {
        RCG_SEL_16M = 2'b00,
        RCG_SEL_8M = 2'b01,
        RCG_SEL_20M = 2'b10
    } rcg_clk_sel_t;

    typedef enum logic [1:0] {
        RCG_RST_ASSERTED = 2'b00,
        RCG_RST_WAIT_EDGE = 2'b01,
        RCG_RST_RUNNING = 2'b10
    } rcg_rst_state_t;

    // rising edge of a sampled level
    function automatic logic rcg_rise(input logic cur, input logic prev);
        return cur & ~prev;
    endfunction

    // strap decode; 20 MHz only if the oscillator is fitted
    function automatic rcg_clk_sel_t rcg_decode_sel(input logic [2:0] s, input logic osc_fit);
        if (s == 3'h4) begin
            return RCG_SEL_8M;
        end else if (s == 3'h2 && osc_fit) begin
            return RCG_SEL_20M;
        end else begin
            return RCG_SEL_16M;
        end
    endfunction

endpackage

// ---- verilog/rcg_top.sv ----
// How it works
// - hard reset high forces board reset low
// - soft reset request low asserts board reset
// - factory test low ignores soft reset request
// - board reset returns board and modules known
// - halt low until delay after supply valid
// - hard reset follows halt, true copy inverted
// - relay supply status readable, low below threshold
// - backplane clock buffered, halved to 8 MHz
// - 8 MHz halved to 4 MHz timer clock
// - one cpu clock: 8, 16 or 20
// - 20 MHz only from fitted local oscillator
// - third strap alone gives 8, first gives 16
`timescale 1ns/10ps
`default_nettype none
module rcg_top #(
    parameter int POR_DELAY_CYC = rcg_pkg::POR_DELAY_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [rcg_pkg::ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    input wire logic supply_5v_valid,
    input wire logic relay_supply_ok,
    input wire logic soft_reset_req_n,
    input wire logic factory_test_n,
    input wire logic backplane_sys_clk,
    input wire logic osc_20m,
    input wire logic osc_20m_fitted,
    input wire logic [2:0] clk_sel_strap,
    output logic halt_n,
    output logic hard_reset_n,
    output logic hard_reset_true,
    output logic board_reset_n,
    output logic buffered_sys_clk,
    output logic clk_8m,
    output logic timer_clk,
    output logic cpu_clk
);

    localparam int CW = rcg_pkg::CNT_W;
    localparam logic [CW-1:0] POR_LAST = CW'(POR_DELAY_CYC - 1);

    typedef struct packed {
        logic [CW-1:0] por_cnt;
        logic halt_n;
        logic hard_n;
        logic hard_true;
        rcg_pkg::rcg_rst_state_t rst_state;
        logic board_n;
        logic [2:0] straps;
        logic osc_fit;
        logic straps_taken;
        logic relay_ok;
        logic relay_ok_d;
        logic supply_d;
        logic soft_en;
        logic [rcg_pkg::IRQ_W-1:0] irq_st;
        logic [rcg_pkg::IRQ_W-1:0] irq_mask;
        logic irq;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } rcg_top_state_t;

    // hard reset true and board reset active out of reset
    localparam rcg_top_state_t ST_RESET = '{
        por_cnt: '0,
        halt_n: 1'b0,
        hard_n: 1'b0,
        hard_true: 1'b1,
        rst_state: rcg_pkg::RCG_RST_ASSERTED,
        board_n: 1'b0,
        straps: 3'h0,
        osc_fit: 1'b0,
        straps_taken: 1'b0,
        relay_ok: 1'b0,
        relay_ok_d: 1'b0,
        supply_d: 1'b0,
        soft_en: rcg_pkg::CTRL_SOFT_EN_RST,
        irq_st: '0,
        irq_mask: rcg_pkg::IRQ_MASK_RST,
        irq: 1'b0,
        prdata: rcg_pkg::RDATA_ZERO,
        pready: 1'b0,
        pslverr: 1'b0
    };

    rcg_top_state_t st_reg;
    rcg_top_state_t st_next;
    rcg_clk_if cif();

    logic soft_req;
    logic rst_req;
    logic apb_setup;
    logic apb_write;
    logic [rcg_pkg::IRQ_W-1:0] irq_set;
    rcg_pkg::rcg_clk_sel_t clk_sel;

    ////////////////////////////////////////////////////////////////////////
    // clock generation
    assign clk_sel = rcg_pkg::rcg_decode_sel(st_reg.straps, st_reg.osc_fit);
    assign cif.sys_clk_in = backplane_sys_clk;
    assign cif.osc_in = osc_20m;
    assign cif.sel = clk_sel;

    rcg_clk_gen u_clk_gen (
        .pclk(pclk),
        .presetn(presetn),
        .cif(cif.gen)
    );

    ////////////////////////////////////////////////////////////////////////
    // reset request terms; factory test masks the soft path only
    assign soft_req = ~soft_reset_req_n & factory_test_n & st_reg.soft_en;
    assign rst_req = st_reg.hard_true | soft_req;
    assign apb_setup = psel & ~penable;
    assign apb_write = psel & penable & st_reg.pready & pwrite;

    // events; software clear loses to a same-cycle set
    always_comb begin
        irq_set = '0;
        irq_set[rcg_pkg::IRQ_RELAY_LOW] = rcg_pkg::rcg_rise(st_reg.relay_ok_d, st_reg.relay_ok);
        irq_set[rcg_pkg::IRQ_SOFT_RST] = soft_req & st_reg.board_n;
        irq_set[rcg_pkg::IRQ_SUPPLY_LOSS] = rcg_pkg::rcg_rise(st_reg.supply_d, supply_5v_valid);
    end

    ////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        st_next = st_reg;

        // straps caught once, on the first edge after release
        if (!st_reg.straps_taken) begin
            st_next.straps = clk_sel_strap;
            st_next.osc_fit = osc_20m_fitted;
            st_next.straps_taken = 1'b1;
        end

        // power-on hold-off: restarts whenever the 5 V supply drops
        if (!supply_5v_valid) begin
            st_next.por_cnt = '0;
            st_next.halt_n = 1'b0;
        end else if (st_reg.por_cnt != POR_LAST) begin
            st_next.por_cnt = st_reg.por_cnt + CW'(1);
        end else begin
            st_next.halt_n = 1'b1;
        end
        st_next.hard_n = st_next.halt_n;
        st_next.hard_true = ~st_next.halt_n;
        st_next.supply_d = supply_5v_valid;

        // relay supply comparator, kept for status
        st_next.relay_ok = relay_supply_ok;
        st_next.relay_ok_d = st_reg.relay_ok;

        // assert at once, release only on a cpu clock rising edge
        case (st_reg.rst_state)
            rcg_pkg::RCG_RST_ASSERTED: begin
                st_next.board_n = 1'b0;
                if (!rst_req) begin
                    st_next.rst_state = rcg_pkg::RCG_RST_WAIT_EDGE;
                end
            end
            rcg_pkg::RCG_RST_WAIT_EDGE: begin
                if (rst_req) begin
                    st_next.rst_state = rcg_pkg::RCG_RST_ASSERTED;
                end else if (cif.cpu_rise) begin
                    st_next.rst_state = rcg_pkg::RCG_RST_RUNNING;
                    st_next.board_n = 1'b1;
                end
            end
            rcg_pkg::RCG_RST_RUNNING: begin
                if (rst_req) begin
                    st_next.rst_state = rcg_pkg::RCG_RST_ASSERTED;
                    st_next.board_n = 1'b0;
                end
            end
            default: begin
                st_next.rst_state = rcg_pkg::RCG_RST_ASSERTED;
                st_next.board_n = 1'b0;
            end
        endcase

        // apb writes take effect in the access phase
        st_next.irq_st = st_reg.irq_st;
        if (apb_write) begin
            case (paddr)
                rcg_pkg::ADDR_CTRL: begin
                    st_next.soft_en = pwdata[rcg_pkg::CTRL_SOFT_EN];
                end
                rcg_pkg::ADDR_IRQ_ST: begin
                    st_next.irq_st = st_reg.irq_st & ~pwdata[rcg_pkg::IRQ_W-1:0];
                end
                rcg_pkg::ADDR_IRQ_MASK: begin
                    st_next.irq_mask = pwdata[rcg_pkg::IRQ_W-1:0];
                end
                default: begin
                    st_next.soft_en = st_reg.soft_en;
                end
            endcase
        end
        st_next.irq_st = st_next.irq_st | irq_set;
        st_next.irq = |(st_reg.irq_st & st_reg.irq_mask);

        // read data registered in setup, so access completes in one cycle
        st_next.pready = apb_setup;
        st_next.pslverr = 1'b0;
        st_next.prdata = rcg_pkg::RDATA_ZERO;
        if (apb_setup) begin
            case (paddr)
                rcg_pkg::ADDR_STATUS: begin
                    st_next.prdata[rcg_pkg::ST_HALT_N] = st_reg.halt_n;
                    st_next.prdata[rcg_pkg::ST_HARD_TRUE] = st_reg.hard_true;
                    st_next.prdata[rcg_pkg::ST_BOARD_N] = st_reg.board_n;
                    st_next.prdata[rcg_pkg::ST_RELAY_OK] = st_reg.relay_ok;
                    st_next.prdata[rcg_pkg::ST_FTEST_N] = factory_test_n;
                    st_next.prdata[rcg_pkg::ST_SEL_LSB +: 2] = clk_sel;
                end
                rcg_pkg::ADDR_CTRL: begin
                    st_next.prdata[rcg_pkg::CTRL_SOFT_EN] = st_reg.soft_en;
                end
                rcg_pkg::ADDR_IRQ_ST: begin
                    st_next.prdata[rcg_pkg::IRQ_W-1:0] = st_reg.irq_st;
                end
                rcg_pkg::ADDR_IRQ_MASK: begin
                    st_next.prdata[rcg_pkg::IRQ_W-1:0] = st_reg.irq_mask;
                end
                default: begin
                    st_next.pslverr = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= ST_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs, all registered
    assign prdata = st_reg.prdata;
    assign pready = st_reg.pready;
    assign pslverr = st_reg.pslverr;
    assign irq = st_reg.irq;
    assign halt_n = st_reg.halt_n;
    assign hard_reset_n = st_reg.hard_n;
    assign hard_reset_true = st_reg.hard_true;
    assign board_reset_n = st_reg.board_n;
    assign buffered_sys_clk = cif.buffered;
    assign clk_8m = cif.clk_8m;
    assign timer_clk = cif.clk_4m;
    assign cpu_clk = cif.cpu_clk;

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_soft_req;
        !soft_reset_req_n && factory_test_n && st_reg.soft_en;
    endsequence

    sequence s_hold_quiet;
        !factory_test_n && !hard_reset_true && board_reset_n;
    endsequence

    property p_soft_asserts;
        s_soft_req |=> !board_reset_n;
    endproperty

    property p_ftest_blocks;
        s_hold_quiet |=> board_reset_n;
    endproperty

    AST_HARD_FORCES_RESET: assert property (hard_reset_true |=> !board_reset_n)
        else $error("board reset not active during hard reset");
    AST_SOFT_ASSERTS: assert property (p_soft_asserts)
        else $error("soft reset request did not reset board");
    AST_FTEST_BLOCKS: assert property (p_ftest_blocks)
        else $error("board reset asserted while factory test masks soft");
    AST_HALT_LOW_NO_SUPPLY: assert property (!supply_5v_valid |=> !halt_n)
        else $error("halt released without valid supply");
    AST_HALT_AFTER_DELAY: assert property ($rose(halt_n) |-> $past(st_reg.por_cnt) == POR_LAST)
        else $error("halt released before hold-off expired");
    AST_HARD_PAIR: assert property (hard_reset_n == halt_n && hard_reset_true == !halt_n)
        else $error("hard reset pair does not follow halt");
    AST_RELAY_STATUS: assert property (!relay_supply_ok |=> !st_reg.relay_ok)
        else $error("relay status not tracking comparator");
    AST_DIV2: assert property ($rose(buffered_sys_clk) |-> $changed(clk_8m))
        else $error("8 MHz clock did not toggle on backplane edge");
    AST_DIV4: assert property ($rose(clk_8m) |-> $changed(timer_clk))
        else $error("timer clock did not toggle on 8 MHz rise");
    AST_SYNC_RELEASE: assert property ($rose(board_reset_n) |-> $past(cif.cpu_rise))
        else $error("board reset released off a cpu clock edge");
    AST_IRQ_LEVEL: assert property ((|(st_reg.irq_st & st_reg.irq_mask)) |=> irq)
        else $error("unmasked status did not raise interrupt");

    // cpu clock lands in the same register stage as its source, no extra lag
    property p_cpu_on_8m;
        (clk_sel == rcg_pkg::RCG_SEL_8M) |=> (cpu_clk == clk_8m);
    endproperty

    property p_cpu_on_16m;
        (clk_sel == rcg_pkg::RCG_SEL_16M) |=> (cpu_clk == buffered_sys_clk);
    endproperty

    property p_set_wins;
        (|irq_set) |=> ((st_reg.irq_st & $past(irq_set)) == $past(irq_set));
    endproperty

    property p_release_quiet;
        $rose(board_reset_n) |-> (!$past(rst_req) && !$past(rst_req, 2));
    endproperty

    // a ready held past one cycle would apply a write twice
    AST_APB_READY: assert property (apb_setup |=> pready)
        else $error("no ready in the access cycle");
    AST_APB_READY_ONE: assert property (pready |=> !pready)
        else $error("ready held past one cycle");
    AST_APB_ERR_QUAL: assert property (pslverr |-> pready)
        else $error("slave error without ready");
    AST_SEL_8M: assert property (p_cpu_on_8m)
        else $error("cpu clock not on the 8 MHz divider");
    AST_SEL_16M: assert property (p_cpu_on_16m)
        else $error("cpu clock not on the backplane copy");
    AST_IRQ_SET_WINS: assert property (p_set_wins)
        else $error("event lost to a same-cycle clear");
    AST_RELEASE_QUIET: assert property (p_release_quiet)
        else $error("board reset released too soon after request");

endmodule
`default_nettype wire
